// ### design/pesc_pkg.sv
// package of constants and types for the exception sync controller
package pesc_pkg;
    // vector offsets
    localparam logic [19:0] PESC_VEC_PERF_MON = 20'h0_0F00;
    localparam logic [19:0] PESC_VEC_IMPL_LO = 20'h0_1000;
    localparam logic [19:0] PESC_VEC_IMPL_HI = 20'h0_2FFF;
    localparam logic [19:0] PESC_VEC_RESERVED = 20'h0_0E00;
    // instruction word step for the next program counter
    localparam logic [63:0] PESC_INSN_STEP = 64'h0000_0000_0000_0004;
    // reset values
    localparam logic [63:0] PESC_PC_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] PESC_STATE_RESET = 64'h0000_0000_0000_0000;
    localparam logic [19:0] PESC_VEC_RESET = 20'h0_0000;

    // kind of synchronizing operation requested by completion
    typedef enum logic [1:0] {
        PESC_OP_EXEC_SYNC,
        PESC_OP_CTX_SYNC,
        PESC_OP_FETCH_BARRIER,
        PESC_OP_MEM_BARRIER
    } pesc_op_type;

    typedef enum {
        PESC_IDLE,
        PESC_DRAIN,
        PESC_ENTER,
        PESC_SYNC_DRAIN,
        PESC_SYNC_DONE
    } pesc_state_type;
endpackage : pesc_pkg

// ### design/pesc_ctrl.sv
// exception entry and synchronization controller
`timescale 1ns/10ps

// Function
// - perf monitor vector reserved when unused
// - implementation range never given architected exceptions
// - saved pc picks excepting or next instruction
// - halt dispatch, drain older instructions first
// - older instructions finish in original context
// - hardware loads saved pc and state
// - context sync halts fetch and dispatch
// - start only after all exceptions reported
// - older ops keep context, ref/change exempt
// - wait until no higher priority pending
// - discard prefetched work, refetch new context
// - no wait on memory or ref/change
// - exec sync: halt and drain only
// - new context by next context sync
// - system call saves following instruction address
// - saved pc is oldest uncompleted instruction
// - older reach no-exception point before handling
// - no younger instruction appears started
// - same-cycle exceptions taken oldest first
module pesc_ctrl
    import pesc_pkg::*;
#(
    parameter int PC_WIDTH = 64,
    parameter int LANES = 2,
    parameter bit PERF_MON_PRESENT = 1'b0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // exception reports, lane 0 is oldest
    input wire logic [LANES-1:0] exc_valid,
    input wire logic [LANES-1:0] exc_is_syscall,
    input wire logic [LANES-1:0] exc_after,
    input wire logic [LANES*20-1:0] exc_vector,
    input wire logic [LANES*PC_WIDTH-1:0] exc_pc,
    input wire logic higher_prio_pending,
    // older instructions all past their last exception point
    input wire logic older_exc_clear,
    input wire logic [63:0] machine_state,
    // synchronizing instruction request
    input wire logic sync_req,
    input wire logic [1:0] sync_op,
    // outputs
    output logic halt_fetch,
    output logic halt_dispatch,
    output logic flush_younger,
    output logic context_freeze,
    output logic sync_complete,
    output logic exc_taken,
    output logic [19:0] vector_addr,
    output logic [PC_WIDTH-1:0] saved_program_counter,
    output logic [63:0] saved_state_copy,
    output logic refetch_valid,
    output logic [PC_WIDTH-1:0] refetch_pc
);
    // ------------------------------------------------------------
    // lane selection
    // ------------------------------------------------------------
    pesc_state_type state_reg, state_next;
    logic [LANES-1:0] pick;
    logic [PC_WIDTH-1:0] pick_pc;
    logic [19:0] pick_vec;
    logic pick_sys;
    logic pick_after;
    logic any_exc;
    logic vec_ok;
    logic [PC_WIDTH-1:0] chosen_pc;
    logic [PC_WIDTH-1:0] pend_pc_reg;
    logic [19:0] pend_vec_reg;
    logic pend_ctx_reg;
    pesc_op_type op_in;

    assign any_exc = |exc_valid;
    assign op_in = pesc_op_type'(sync_op);

    // lanes are ordered by age, so a plain scan from the youngest
    // lane down leaves the oldest reporter in the pick; this keeps
    // one entry per take and the rest wait for a later idle cycle
    // oldest reporting lane wins; younger reports retried later
    always_comb begin
        pick = '0;
        pick_pc = '0;
        pick_vec = '0;
        pick_sys = 1'b0;
        pick_after = 1'b0;
        for (int i = LANES - 1; i >= 0; i--) begin
            if (exc_valid[i]) begin
                pick = '0;
                pick[i] = 1'b1;
                pick_pc = exc_pc[i*PC_WIDTH +: PC_WIDTH];
                pick_vec = exc_vector[i*20 +: 20];
                pick_sys = exc_is_syscall[i];
                pick_after = exc_after[i];
            end
        end
    end

    // unused perf vector and implementation range are refused
    wire perf_block = !PERF_MON_PRESENT && pick_vec == PESC_VEC_PERF_MON;
    wire impl_hit = pick_vec >= PESC_VEC_IMPL_LO &&
                    pick_vec <= PESC_VEC_IMPL_HI;
    assign vec_ok = !perf_block && !impl_hit;

    // system call and after-type status address the next word
    wire step_next = pick_sys || pick_after;
    assign chosen_pc = step_next ?
        pick_pc + PESC_INSN_STEP[PC_WIDTH-1:0] : pick_pc;
    wire [19:0] chosen_vec = vec_ok ? pick_vec : PESC_VEC_RESERVED;

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    // handshake timing, one step per clock with clk_en high:
    //   idle    a report or request is taken and captured
    //   drain   halts and context freeze stand, pipeline empties
    //   enter   saved registers load, younger work is flushed
    //   done    sync pulse, refetch only for context sync and fetch barrier
    // a report that is taken away while draining still completes
    // entry: the lane was captured at take, so it is not retried
    // a second report must stay up until the next idle cycle
    // waits only on exception reporting and, for entry, on higher priority clearing, never on memory traffic
    wire can_start = older_exc_clear && !higher_prio_pending;
    wire exc_start = state_reg == PESC_IDLE && any_exc;
    wire sync_start = state_reg == PESC_IDLE && !any_exc && sync_req;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PESC_IDLE: begin
                if (any_exc) begin
                    state_next = PESC_DRAIN;
                end else if (sync_req) begin
                    state_next = PESC_SYNC_DRAIN;
                end
            end
            PESC_DRAIN: begin
                if (can_start) begin
                    state_next = PESC_ENTER;
                end
            end
            PESC_ENTER: begin
                state_next = PESC_IDLE;
            end
            PESC_SYNC_DRAIN: begin
                if (older_exc_clear) begin
                    state_next = PESC_SYNC_DONE;
                end
            end
            PESC_SYNC_DONE: begin
                state_next = PESC_IDLE;
            end
            default: begin
                state_next = PESC_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // output decode
    // ------------------------------------------------------------
    wire busy_next = state_next != PESC_IDLE;
    // exec sync and barriers still halt fetch while draining
    wire halt_next = busy_next;
    // context held for older work until entry or sync end
    wire freeze_next = state_next == PESC_DRAIN ||
                       state_next == PESC_SYNC_DRAIN;
    wire enter_next = state_next == PESC_ENTER;
    wire done_next = state_next == PESC_SYNC_DONE;
    // context sync discards prefetch; exec sync lets it drift
    wire flush_next = enter_next || (done_next && pend_ctx_reg);
    // only context sync and fetch barrier change what is fetched;
    // exec sync and memory barrier leave prefetched work alone
    wire sync_refetch = op_in == PESC_OP_CTX_SYNC ||
                        op_in == PESC_OP_FETCH_BARRIER;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // every register holds its value while clock enable is low
    // state register, frozen while clock enable is low
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= PESC_IDLE;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // capture of the chosen exception at its start
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pend_pc_reg <= PESC_PC_RESET[PC_WIDTH-1:0];
            pend_vec_reg <= PESC_VEC_RESET;
        end else if (clk_en && exc_start) begin
            pend_pc_reg <= chosen_pc;
            pend_vec_reg <= chosen_vec;
        end
    end

    // exceptions and refetching syncs both discard prefetched work
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pend_ctx_reg <= 1'b0;
        end else if (clk_en) begin
            if (exc_start) begin
                pend_ctx_reg <= 1'b1;
            end else if (sync_start) begin
                pend_ctx_reg <= sync_refetch;
            end
        end
    end

    // fetch halt while any operation is in flight
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            halt_fetch <= 1'b0;
        end else if (clk_en) begin
            halt_fetch <= halt_next;
        end
    end

    // dispatch halt, same timing as the fetch halt
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            halt_dispatch <= 1'b0;
        end else if (clk_en) begin
            halt_dispatch <= halt_next;
        end
    end

    // context held only while older work drains
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            context_freeze <= 1'b0;
        end else if (clk_en) begin
            context_freeze <= freeze_next;
        end
    end

    // one cycle flush of younger work
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flush_younger <= 1'b0;
        end else if (clk_en) begin
            flush_younger <= flush_next;
        end
    end

    // entry pulse
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            exc_taken <= 1'b0;
        end else if (clk_en) begin
            exc_taken <= enter_next;
        end
    end

    // sync completion pulse
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync_complete <= 1'b0;
        end else if (clk_en) begin
            sync_complete <= done_next;
        end
    end

    // saved registers loaded by hardware at entry only
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            saved_program_counter <= PESC_PC_RESET[PC_WIDTH-1:0];
            saved_state_copy <= PESC_STATE_RESET;
        end else if (clk_en && enter_next) begin
            saved_program_counter <= pend_pc_reg;
            saved_state_copy <= machine_state;
        end
    end

    // handler vector and refetch address, also set at entry only;
    // a sync leaves both alone since it refetches in line
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vector_addr <= PESC_VEC_RESET;
            refetch_pc <= PESC_PC_RESET[PC_WIDTH-1:0];
        end else if (clk_en && enter_next) begin
            vector_addr <= pend_vec_reg;
            refetch_pc <= PC_WIDTH'(pend_vec_reg);
        end
    end

    // refetch strobe travels with the flush
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            refetch_valid <= 1'b0;
        end else if (clk_en) begin
            refetch_valid <= flush_next;
        end
    end
endmodule : pesc_ctrl

// ### verification/pesc_ctrl_assertions.sv
// checker on the ports of the exception sync controller
`timescale 1ns/10ps
module pesc_ctrl_assertions
    import pesc_pkg::*;
#(
    parameter bit PERF_MON_PRESENT = 1'b0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic higher_prio_pending,
    input wire logic older_exc_clear,
    input wire logic halt_fetch,
    input wire logic halt_dispatch,
    input wire logic flush_younger,
    input wire logic context_freeze,
    input wire logic sync_complete,
    input wire logic exc_taken,
    input wire logic [19:0] vector_addr,
    input wire logic refetch_valid
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_taken_halts: assert property (exc_taken |-> halt_fetch && halt_dispatch)
        else $error("halts low at entry");
    a_entry_drained: assert property (exc_taken |-> $past(older_exc_clear) || $past(older_exc_clear, 2))
        else $error("entry before older work drained");
    a_prio_wait: assert property (exc_taken |-> !$past(higher_prio_pending) || !$past(higher_prio_pending, 2))
        else $error("entry while higher priority pending");
    a_entry_pulse: assert property (exc_taken |=> !exc_taken)
        else $error("entry pulse too long");
    a_flush_refetch: assert property (flush_younger == refetch_valid)
        else $error("flush and refetch apart");
    a_impl_range: assert property (exc_taken |-> !(vector_addr inside {[PESC_VEC_IMPL_LO:PESC_VEC_IMPL_HI]}))
        else $error("vector in implementation range");
    a_perf_resv: assert property (exc_taken && !PERF_MON_PRESENT |-> vector_addr != PESC_VEC_PERF_MON)
        else $error("unused monitor vector taken");
    a_sync_drain: assert property (sync_complete |-> $past(older_exc_clear) && $past(halt_fetch))
        else $error("sync done before drain");
    a_freeze_halt: assert property (context_freeze |-> halt_dispatch)
        else $error("freeze without halt");
    a_halt_pair: assert property (halt_fetch == halt_dispatch)
        else $error("fetch and dispatch halts differ");
    a_entry_flush: assert property (exc_taken |-> flush_younger)
        else $error("younger work kept at entry");
    c_entry: cover property (exc_taken);
    c_sync: cover property (sync_complete);
    c_prio: cover property (higher_prio_pending && halt_dispatch);
endmodule : pesc_ctrl_assertions

// ### verification/pesc_pipe_model.sv
// pipeline model that drains older work after a halt
`timescale 1ns/10ps
module pesc_pipe_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic halt_dispatch,
    input wire logic [1:0] drain_delay,
    output logic older_exc_clear
);
    logic [2:0] wait_reg;
    // clear drops with the halt, so a stale clear never starts an entry
    always @(negedge clk) begin
        if (!reset_n || !halt_dispatch) begin
            wait_reg <= {1'b0, drain_delay};
            older_exc_clear <= 1'b0;
        end else if (wait_reg != 3'h0) begin
            wait_reg <= wait_reg - 3'h1;
        end else begin
            older_exc_clear <= 1'b1;
        end
    end
endmodule : pesc_pipe_model

// ### verification/precise_exception_sync_ctrl_tb.sv
// self-checking bench for the exception sync controller
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
failures++; $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module precise_exception_sync_ctrl_tb;
    import pesc_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, hp = 1'b0, sreq = 1'b0, ocl;
    logic [1:0] ev, sys, aft, sop, dly;
    logic [39:0] vec;
    logic [127:0] pc;
    logic [63:0] ms, spc, ssc, rpc;
    logic hf, hd, fl, cf, sc, et, rv;
    logic [19:0] va;
    logic [31:0] seed = 32'h0000_0aca;
    int failures = 0, n_checks = 0;
    logic [19:0] vtab [6] = '{20'h0_0700, 20'h0_0C00, 20'h0_0F00,
        20'h0_1000, 20'h0_2FFF, 20'h0_0300};
    always #2 clk = ~clk;
    pesc_ctrl u_dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
        .exc_valid(ev), .exc_is_syscall(sys), .exc_after(aft),
        .exc_vector(vec), .exc_pc(pc), .higher_prio_pending(hp),
        .older_exc_clear(ocl), .machine_state(ms), .sync_req(sreq),
        .sync_op(sop), .halt_fetch(hf), .halt_dispatch(hd),
        .flush_younger(fl), .context_freeze(cf), .sync_complete(sc),
        .exc_taken(et), .vector_addr(va), .saved_program_counter(spc),
        .saved_state_copy(ssc), .refetch_valid(rv), .refetch_pc(rpc));
    pesc_pipe_model u_pipe (.clk(clk), .reset_n(reset_n),
        .halt_dispatch(hd), .drain_delay(dly), .older_exc_clear(ocl));
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // reserved slots come back as the replacement vector
    function automatic logic [19:0] exp_vec(input logic [19:0] v);
        return (v == PESC_VEC_PERF_MON || (v >= PESC_VEC_IMPL_LO &&
            v <= PESC_VEC_IMPL_HI)) ? PESC_VEC_RESERVED : v;
    endfunction : exp_vec
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    // lanes keep reporting until taken; priority held off a few cycles
    task automatic do_exc(input logic [31:0] r);
        int k;
        int ln;
        logic [63:0] p;
        logic fz;
        ev = (r[5:4] == 2'b00) ? 2'b10 : r[5:4];
        {sys, aft, dly} = {r[7:6], r[15:14], r[30:29]};
        vec = {vtab[r[10:8] % 3'd6], vtab[r[13:11] % 3'd6]};
        pc = {rnd(), rnd(), rnd(), rnd()};
        ms = {rnd(), rnd()};
        ln = ev[0] ? 0 : 1;
        p = pc[ln*64 +: 64] + ((sys[ln] | aft[ln]) ? PESC_INSN_STEP : '0);
        fz = 1'b0;
        for (k = 0; k < 30; k++) begin
            hp = (k < 3) & r[16+k];
            @(negedge clk);
            fz |= cf;
            if (et === 1'b1) break;
        end
        if (k == 30) begin
            failures++;
            final_report();
        end
        `CHK("saved pc", p, spc)
        `CHK("saved state", ms, ssc)
        `CHK("vector", exp_vec(vec[ln*20 +: 20]), va)
        `CHK("refetch pc", {44'h0, exp_vec(vec[ln*20 +: 20])}, rpc)
        `CHK("flush", 1'b1, fl)
        `CHK("freeze in drain", 1'b1, fz)
        `CHK("freeze at entry", 1'b0, cf)
        {ev, hp} = '0;
        @(negedge clk);
        `CHK("halt release", 1'b0, hd)
    endtask : do_exc
    // flush only for ops that change what is fetched next
    task automatic do_sync(input logic [1:0] op);
        int k;
        logic fs;
        logic hs;
        {fs, hs, sop, sreq} = {2'b00, op, 1'b1};
        for (k = 0; k < 30; k++) begin
            @(negedge clk);
            {fs, hs} = {fs | fl, hs | hf};
            if (sc === 1'b1) break;
        end
        if (k == 30) begin
            failures++;
            final_report();
        end
        sreq = 1'b0;
        @(negedge clk);
        fs |= fl;
        `CHK("sync flush", (op == 2'd1 || op == 2'd2), fs)
        `CHK("sync halted", 1'b1, hs)
    endtask : do_sync
    initial begin
        {ev, sys, aft, vec, pc, ms, sop, dly} = '0;
        repeat (4) @(posedge clk);
        @(negedge clk) reset_n = 1'b1;
        do_exc(32'h0003_1230);
        for (int i = 0; i < 4; i++) do_sync(i[1:0]);
        for (int i = 0; i < 60; i++) begin
            if (rnd() % 4 == 0) do_sync(seed[9:8]);
            else do_exc(rnd());
        end
        final_report();
    end
endmodule : precise_exception_sync_ctrl_tb
bind pesc_ctrl pesc_ctrl_assertions #(.PERF_MON_PRESENT(PERF_MON_PRESENT))
    u_chk (.clk(clk), .reset_n(reset_n), .exc_taken(exc_taken),
    .higher_prio_pending(higher_prio_pending), .halt_fetch(halt_fetch),
    .older_exc_clear(older_exc_clear), .halt_dispatch(halt_dispatch),
    .flush_younger(flush_younger), .context_freeze(context_freeze),
    .sync_complete(sync_complete), .vector_addr(vector_addr),
    .refetch_valid(refetch_valid));
